/* inc/cirf_pkg.sv */
package cirf_pkg;
    // memory map of the internal data space
    localparam logic [7:0]  CIRF_LOWER_TOP   = 8'h7f;
    localparam logic [7:0]  CIRF_BIT_BASE    = 8'h20;
    localparam logic [7:0]  CIRF_BIT_SFR_MIN = 8'h80;
    localparam logic [3:0]  CIRF_BIT_NIB_A   = 4'h0;
    localparam logic [3:0]  CIRF_BIT_NIB_B   = 4'h8;
    localparam logic [7:0]  CIRF_PSW_ADDR    = 8'hd0;
    localparam logic [7:0]  CIRF_SP_ADDR     = 8'h81;
    localparam logic [7:0]  CIRF_ACC_ADDR    = 8'he0;
    localparam logic [7:0]  CIRF_SP_RESET    = 8'h07;
    localparam logic [7:0]  CIRF_PSW_RESET   = 8'h00;
    localparam logic [7:0]  CIRF_ACC_RESET   = 8'h00;
    // program memory vectors
    localparam logic [15:0] CIRF_RESET_VEC   = 16'h0000;
    localparam logic [15:0] CIRF_VEC_BASE    = 16'h0003;
    localparam int          CIRF_VEC_STEP    = 8;
    // status word bit positions
    localparam int CIRF_CY_BIT  = 7;
    localparam int CIRF_AC_BIT  = 6;
    localparam int CIRF_UFA_BIT = 5;
    localparam int CIRF_RSH_BIT = 4;
    localparam int CIRF_RSL_BIT = 3;
    localparam int CIRF_OV_BIT  = 2;
    localparam int CIRF_UFB_BIT = 1;
    localparam int CIRF_P_BIT   = 0;

    // kind of operation reported by the execution logic
    typedef enum logic [2:0] {
        CIRF_OP_NONE,
        CIRF_OP_ADD,
        CIRF_OP_SUB,
        CIRF_OP_MUL,
        CIRF_OP_DIV,
        CIRF_OP_OTHER
    } cirf_op_t;

    // addressing mode of a data access
    typedef enum logic [1:0] {
        CIRF_AM_DIRECT,
        CIRF_AM_INDIRECT,
        CIRF_AM_REGISTER,
        CIRF_AM_BIT
    } cirf_am_t;

    // one data space access request
    typedef struct packed {
        logic       valid;
        logic       write;
        cirf_am_t   mode;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cirf_req_t;

    // arithmetic result report
    typedef struct packed {
        logic       valid;
        cirf_op_t   op;
        logic [7:0] a;
        logic [7:0] b;
        logic       cin;
        logic [7:0] acc_new;
    } cirf_alu_t;
endpackage

/* rtl/cirf_core.sv */
`timescale 1ns/10ps
module cirf_core #(
    parameter int RAM_DEPTH = 256
) (
    input  wire logic                 clock,
    input  wire logic                 resetn,
    input  wire cirf_pkg::cirf_req_t  req,
    input  wire cirf_pkg::cirf_alu_t  alu,
    input  wire logic                 push,
    input  wire logic                 pop,
    input  wire logic                 irq_take,
    input  wire logic [2:0]           irq_index,
    output logic [7:0]                rdata,
    output logic                      rvalid,
    output logic [7:0]                sfr_addr,
    output logic                      sfr_write,
    output logic                      sfr_read,
    output logic [7:0]                sfr_wdata,
    output logic [15:0]               fetch_addr,
    output logic                      fetch_load,
    output logic [7:0]                program_status_word,
    output logic [7:0]                stack_pointer
);
    import cirf_pkg::*;

    logic [1:0]  rst_sync;
    logic        rst_n;
    logic [7:0]  ram [RAM_DEPTH];
    logic [7:0]  acc;
    logic        carry_flag;
    logic        auxiliary_carry_flag;
    logic        user_flag_a;
    logic        bank_select_high;
    logic        bank_select_low;
    logic        overflow_flag;
    logic        user_flag_b;
    logic        parity;
    logic        boot_done;

    // resolved target of the current request
    logic        hit_ram;
    logic        hit_sfr;
    logic        hit_bit;
    logic [7:0]  ram_addr;
    logic [2:0]  bit_pos;
    logic [7:0]  bit_byte;
    logic [7:0]  next_sp;

    // reset released through two flops so release is clean
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // vector address of interrupt n, eight bytes apart
    function automatic logic [15:0] vec_addr(input logic [2:0] n);
        vec_addr = CIRF_VEC_BASE + 16'(n) * 16'(CIRF_VEC_STEP);
    endfunction

    // true when a special-function byte address may be bit addressed
    function automatic logic sfr_bitable(input logic [7:0] a);
        sfr_bitable = (a[3:0] == CIRF_BIT_NIB_A) || (a[3:0] == CIRF_BIT_NIB_B);
    endfunction

    // address decode; direct above 7fH goes to sfr space, indirect to ram
    always_comb begin
        hit_ram  = 1'b0;
        hit_sfr  = 1'b0;
        hit_bit  = 1'b0;
        ram_addr = req.addr;
        bit_pos  = req.addr[2:0];
        bit_byte = 8'h00;
        if (req.mode == CIRF_AM_REGISTER) begin
            // bank base from the two select bits
            ram_addr = {3'b000, bank_select_high, bank_select_low, req.addr[2:0]};
            hit_ram  = 1'b1;
        end else if (req.mode == CIRF_AM_INDIRECT) begin
            hit_ram = 1'b1;
        end else if (req.mode == CIRF_AM_DIRECT) begin
            if (req.addr <= CIRF_LOWER_TOP) begin
                hit_ram = 1'b1;
            end else begin
                hit_sfr = 1'b1;
            end
        end else begin
            if (req.addr < CIRF_BIT_SFR_MIN) begin
                // bit 00H-7FH maps to bytes 20H-2FH
                ram_addr = CIRF_BIT_BASE + {4'h0, req.addr[6:3]};
                hit_ram  = 1'b1;
                hit_bit  = 1'b1;
            end else begin
                ram_addr = {req.addr[7:3], 3'b000};
                hit_sfr  = sfr_bitable(ram_addr);
                hit_bit  = hit_sfr;
            end
        end
        bit_byte = 8'h01 << bit_pos;
    end

    // local sfrs this block owns; others go out on the sfr port
    logic local_psw;
    logic local_sp;
    logic local_acc;
    assign local_psw = hit_sfr && (ram_addr == CIRF_PSW_ADDR);
    assign local_sp  = hit_sfr && (ram_addr == CIRF_SP_ADDR);
    assign local_acc = hit_sfr && (ram_addr == CIRF_ACC_ADDR);

    logic wr_go;
    assign wr_go = req.valid && req.write;

    // status word as assembled from the flags
    logic [7:0] psw_now;
    always_comb begin
        psw_now               = 8'h00;
        psw_now[CIRF_CY_BIT]  = carry_flag;
        psw_now[CIRF_AC_BIT]  = auxiliary_carry_flag;
        psw_now[CIRF_UFA_BIT] = user_flag_a;
        psw_now[CIRF_RSH_BIT] = bank_select_high;
        psw_now[CIRF_RSL_BIT] = bank_select_low;
        psw_now[CIRF_OV_BIT]  = overflow_flag;
        psw_now[CIRF_UFB_BIT] = user_flag_b;
        psw_now[CIRF_P_BIT]   = parity;
    end

    // byte visible at the decoded location before a write
    logic [7:0] cur_byte;
    always_comb begin
        if (local_psw) begin
            cur_byte = psw_now;
        end else if (local_sp) begin
            cur_byte = stack_pointer;
        end else if (local_acc) begin
            cur_byte = acc;
        end else if (hit_ram) begin
            cur_byte = ram[ram_addr];
        end else begin
            cur_byte = 8'h00;
        end
    end

    // value to store: bit writes merge one bit into the byte
    logic [7:0] store_byte;
    always_comb begin
        if (hit_bit) begin
            store_byte = req.wdata[0] ? (cur_byte | bit_byte) : (cur_byte & ~bit_byte);
        end else begin
            store_byte = req.wdata;
        end
    end

    // stack pointer: pre-increment on push, post-decrement on pop
    always_comb begin
        next_sp = stack_pointer;
        if (push) begin
            next_sp = stack_pointer + 8'h01;
        end else if (pop) begin
            next_sp = stack_pointer - 8'h01;
        end else if (wr_go && local_sp) begin
            next_sp = store_byte;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stack_pointer <= CIRF_SP_RESET;
        end else begin
            stack_pointer <= next_sp;
        end
    end

    // push stores the data byte at the incremented pointer, full 8-bit range
    always_ff @(posedge clock) begin
        if (push) begin
            ram[next_sp] <= req.wdata;
        end else if (wr_go && hit_ram) begin
            ram[ram_addr] <= store_byte;
        end
    end

    // arithmetic flag results
    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic [15:0] prod;
    logic        sign_ov;
    always_comb begin
        sum9    = 9'h000;
        sum5    = 5'h00;
        sign_ov = 1'b0;
        prod    = alu.a * alu.b;
        if (alu.op == CIRF_OP_ADD) begin
            sum9    = {1'b0, alu.a} + {1'b0, alu.b} + {8'h00, alu.cin};
            sum5    = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]} + {4'h0, alu.cin};
            sign_ov = (alu.a[7] == alu.b[7]) && (sum9[7] != alu.a[7]);
        end else if (alu.op == CIRF_OP_SUB) begin
            sum9    = {1'b0, alu.a} - {1'b0, alu.b} - {8'h00, alu.cin};
            sum5    = {1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]} - {4'h0, alu.cin};
            sign_ov = (alu.a[7] != alu.b[7]) && (sum9[7] != alu.a[7]);
        end
    end

    // flags: arithmetic report wins over a software write in same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            carry_flag           <= CIRF_PSW_RESET[CIRF_CY_BIT];
            auxiliary_carry_flag <= CIRF_PSW_RESET[CIRF_AC_BIT];
            user_flag_a          <= CIRF_PSW_RESET[CIRF_UFA_BIT];
            bank_select_high     <= CIRF_PSW_RESET[CIRF_RSH_BIT];
            bank_select_low      <= CIRF_PSW_RESET[CIRF_RSL_BIT];
            overflow_flag        <= CIRF_PSW_RESET[CIRF_OV_BIT];
            user_flag_b          <= CIRF_PSW_RESET[CIRF_UFB_BIT];
        end else begin
            if (wr_go && local_psw) begin
                carry_flag           <= store_byte[CIRF_CY_BIT];
                auxiliary_carry_flag <= store_byte[CIRF_AC_BIT];
                user_flag_a          <= store_byte[CIRF_UFA_BIT];
                bank_select_high     <= store_byte[CIRF_RSH_BIT];
                bank_select_low      <= store_byte[CIRF_RSL_BIT];
                overflow_flag        <= store_byte[CIRF_OV_BIT];
                user_flag_b          <= store_byte[CIRF_UFB_BIT];
            end
            if (alu.valid && (alu.op == CIRF_OP_ADD || alu.op == CIRF_OP_SUB)) begin
                carry_flag           <= sum9[8];
                auxiliary_carry_flag <= sum5[4];
                overflow_flag        <= sign_ov;
            end else if (alu.valid && alu.op == CIRF_OP_MUL) begin
                carry_flag    <= 1'b0;
                overflow_flag <= (prod[15:8] != 8'h00);
            end else if (alu.valid && alu.op == CIRF_OP_DIV) begin
                carry_flag    <= 1'b0;
                overflow_flag <= (alu.b == 8'h00);
            end
        end
    end

    // accumulator copy; parity is recomputed from it every cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc <= CIRF_ACC_RESET;
        end else if (alu.valid && alu.op != CIRF_OP_NONE) begin
            acc <= alu.acc_new;
        end else if (wr_go && local_acc) begin
            acc <= store_byte;
        end
    end
    assign parity = ^acc;

    // read data and sfr port registered, one cycle after the request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata     <= 8'h00;
            rvalid    <= 1'b0;
            sfr_addr  <= 8'h00;
            sfr_write <= 1'b0;
            sfr_read  <= 1'b0;
            sfr_wdata <= 8'h00;
        end else begin
            rvalid    <= req.valid && !req.write;
            rdata     <= hit_bit ? {7'h00, |(cur_byte & bit_byte)} : cur_byte;
            sfr_addr  <= ram_addr;
            sfr_wdata <= store_byte;
            sfr_write <= wr_go && hit_sfr && !(local_psw || local_sp || local_acc);
            sfr_read  <= req.valid && !req.write && hit_sfr
                         && !(local_psw || local_sp || local_acc);
        end
    end

    // fetch redirect: reset vector once, then interrupt vectors
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fetch_addr <= CIRF_RESET_VEC;
            fetch_load <= 1'b0;
            boot_done  <= 1'b0;
        end else if (!boot_done) begin
            fetch_addr <= CIRF_RESET_VEC;
            fetch_load <= 1'b1;
            boot_done  <= 1'b1;
        end else if (irq_take) begin
            fetch_addr <= vec_addr(irq_index);
            fetch_load <= 1'b1;
        end else begin
            fetch_load <= 1'b0;
        end
    end

    assign program_status_word = psw_now;

    // checks
    sp_reset_a: assert property (@(posedge clock)
        $rose(rst_n) |-> stack_pointer == CIRF_SP_RESET)
        else $error("stack pointer not 07H after reset");
    sp_push_a: assert property (@(posedge clock) disable iff (!rst_n)
        push |=> stack_pointer == $past(stack_pointer) + 8'h01)
        else $error("push did not pre-increment pointer");
    parity_acc_a: assert property (@(posedge clock) disable iff (!rst_n)
        program_status_word[0] == ^acc)
        else $error("parity does not follow accumulator");
    // parity judged against the reported result, not the local copy
    parity_load_a: assert property (@(posedge clock) disable iff (!rst_n)
        alu.valid && alu.op != CIRF_OP_NONE
        |=> program_status_word[CIRF_P_BIT] == ^$past(alu.acc_new))
        else $error("parity does not follow loaded result");
    boot_vec_a: assert property (@(posedge clock)
        $rose(rst_n) |=> fetch_load && fetch_addr == CIRF_RESET_VEC)
        else $error("first fetch not at 0000H");
    irq_vec_a: assert property (@(posedge clock) disable iff (!rst_n)
        boot_done && irq_take
        |=> fetch_addr == 16'h0003 + 16'($past(irq_index)) * 16'h0008)
        else $error("interrupt vector address wrong");
    bank_map_a: assert property (@(posedge clock) disable iff (!rst_n)
        req.mode == CIRF_AM_REGISTER
        |-> ram_addr[7:3] == {3'b000, program_status_word[4:3]})
        else $error("register operand outside selected bank");
    indirect_ram_a: assert property (@(posedge clock) disable iff (!rst_n)
        req.valid && req.mode == CIRF_AM_INDIRECT |=> !sfr_write && !sfr_read)
        else $error("indirect access reached sfr space");
    direct_sfr_a: assert property (@(posedge clock) disable iff (!rst_n)
        req.mode == CIRF_AM_DIRECT && req.addr[7] |-> hit_sfr && !hit_ram)
        else $error("direct upper access not sent to sfr");
    mul_ov_a: assert property (@(posedge clock) disable iff (!rst_n)
        alu.valid && alu.op == CIRF_OP_MUL && !(wr_go && local_psw)
        |=> overflow_flag == ($past(alu.a) * $past(alu.b) > 255))
        else $error("mul overflow flag wrong");
    div_ov_a: assert property (@(posedge clock) disable iff (!rst_n)
        alu.valid && alu.op == CIRF_OP_DIV |=> overflow_flag == ($past(alu.b) == 8'h00))
        else $error("div overflow flag wrong");

    push_c: cover property (@(posedge clock) disable iff (!rst_n) push ##1 push);
    bank3_c: cover property (@(posedge clock) disable iff (!rst_n)
        req.valid && req.mode == CIRF_AM_REGISTER && bank_select_high && bank_select_low);
    irq_c: cover property (@(posedge clock) disable iff (!rst_n) boot_done && irq_take);
    bit_c: cover property (@(posedge clock) disable iff (!rst_n) req.valid && hit_bit && req.write);
endmodule

/* verification/cirf_exec_model.sv */
`timescale 1ns/10ps
// stand-in for the execution unit: reports one arithmetic result per go pulse
module cirf_exec_model
    import cirf_pkg::*;
(
    input  wire logic               go,
    input  wire cirf_pkg::cirf_op_t op,
    input  wire logic [7:0]         a,
    input  wire logic [7:0]         b,
    input  wire logic               cin,
    output cirf_pkg::cirf_alu_t     alu
);
    logic [15:0] prod;

    assign prod = a * b;

    // result byte as the real unit would compute it; divide by zero gives ff
    always_comb begin
        alu         = '0;
        alu.valid   = go;
        alu.op      = op;
        alu.a       = a;
        alu.b       = b;
        alu.cin     = cin;
        case (op)
            CIRF_OP_ADD: alu.acc_new = a + b + {7'h00, cin};
            CIRF_OP_SUB: alu.acc_new = a - b - {7'h00, cin};
            CIRF_OP_MUL: alu.acc_new = prod[7:0];
            CIRF_OP_DIV: alu.acc_new = (b == 8'h00) ? 8'hff : a / b;
            default:     alu.acc_new = a;
        endcase
    end
endmodule

/* verification/cpu_internal_ram_and_flags_tb.sv */
`timescale 1ns/10ps
module cpu_internal_ram_and_flags_tb;
    import cirf_pkg::*;

    logic clock = 1'b0;
    logic resetn = 1'b0;
    cirf_req_t req = '0;
    cirf_alu_t alu;
    logic push = 1'b0, pop = 1'b0, irq_take = 1'b0;
    logic [2:0] irq_index = 3'h0;
    logic [7:0] rdata, sfr_addr, sfr_wdata, program_status_word, stack_pointer;
    logic rvalid, sfr_write, sfr_read, fetch_load;
    logic [15:0] fetch_addr;
    logic go = 1'b0, cin = 1'b0;
    cirf_op_t op = CIRF_OP_NONE;
    logic [7:0] a = 8'h00, b = 8'h00, exp_psw = 8'h00;
    int err_total = 0, compares = 0;

    // 50 ns period
    always #25 clock = ~clock;

    cirf_core #(.RAM_DEPTH(256)) i_cirf_core (.clock(clock), .resetn(resetn), .req(req),
        .alu(alu), .push(push), .pop(pop), .irq_take(irq_take), .irq_index(irq_index),
        .rdata(rdata), .rvalid(rvalid), .sfr_addr(sfr_addr), .sfr_write(sfr_write),
        .sfr_read(sfr_read), .sfr_wdata(sfr_wdata), .fetch_addr(fetch_addr),
        .fetch_load(fetch_load), .program_status_word(program_status_word),
        .stack_pointer(stack_pointer));

    cirf_exec_model i_cirf_exec_model (.go(go), .op(op), .a(a), .b(b), .cin(cin), .alu(alu));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
        compares++;
        if (got !== expv) begin
            $display("Error %s expected %h seen %h", what, expv, got);
            err_total++;
        end
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic step;
        @(posedge clock);
        #1;
    endtask

    // request held one cycle; answer is looked at right after the taking edge
    // an idle edge first, so valid never falls and rises in one time step
    task automatic access(input logic wr, input cirf_am_t m, input logic [7:0] ad, wd);
        step;
        req = '{valid: 1'b1, write: wr, mode: m, addr: ad, wdata: wd};
        step;
        req.valid = 1'b0;
    endtask

    task automatic rd_chk(input string what, input cirf_am_t m, input logic [7:0] ad, ev);
        access(1'b0, m, ad, 8'h00);
        chk("read valid", 16'h0001, {15'h0000, rvalid});
        chk(what, {8'h00, ev}, {8'h00, rdata});
    endtask

    // expected flags worked out here, independent of the model's result byte
    task automatic alu_chk(input cirf_op_t o, input logic [7:0] x, y, input logic c);
        logic [8:0]  s;
        logic [15:0] p;
        logic [7:0]  r;
        step;
        op = o; a = x; b = y; cin = c; go = 1'b1;
        step;
        go = 1'b0;
        case (o)
            CIRF_OP_ADD: begin
                s = x + y + c; r = s[7:0]; exp_psw[7] = s[8];
                exp_psw[6] = (x[3:0] + y[3:0] + c) > 5'h0f;
                exp_psw[2] = (x[7] == y[7]) && (r[7] != x[7]);
            end
            CIRF_OP_SUB: begin
                s = {1'b0, x} - y - c; r = s[7:0]; exp_psw[7] = s[8];
                exp_psw[6] = {1'b0, x[3:0]} < (y[3:0] + c);
                exp_psw[2] = (x[7] != y[7]) && (r[7] != x[7]);
            end
            CIRF_OP_MUL: begin
                p = x * y; r = p[7:0]; exp_psw[7] = 1'b0; exp_psw[2] = p > 16'h00ff;
            end
            CIRF_OP_OTHER: begin
                r = x;
            end
            default: begin
                r = (y == 8'h00) ? 8'hff : x / y; exp_psw[7] = 1'b0; exp_psw[2] = (y == 8'h00);
            end
        endcase
        exp_psw[0] = ^r;
        chk("status word", {8'h00, exp_psw}, {8'h00, program_status_word});
    endtask

    // wait for the first fetch load after release, bounded
    task automatic do_reset;
        resetn = 1'b0;
        repeat (12) step;
        chk("stack pointer", 16'h0007, {8'h00, stack_pointer});
        chk("status word", 16'h0000, {8'h00, program_status_word});
        resetn = 1'b1;
        for (int n = 0; n < 8 && fetch_load !== 1'b1; n++) step;
        chk("fetch load", 16'h0001, {15'h0000, fetch_load});
        chk("fetch address", 16'h0000, fetch_addr);
        if (fetch_load !== 1'b1) finish_test;
        step;
        exp_psw = 8'h00;
        $display("test reset done");
    endtask

    initial begin
        do_reset;
        rd_chk("stack pointer", CIRF_AM_DIRECT, CIRF_SP_ADDR, 8'h07);
        access(1'b1, CIRF_AM_DIRECT, CIRF_SP_ADDR, 8'h55);
        chk("stack pointer", 16'h0055, {8'h00, stack_pointer});
        access(1'b1, CIRF_AM_DIRECT, CIRF_SP_ADDR, 8'h07);
        $display("test stack register done");
        // low ram both ways, shared upper range split by mode
        access(1'b1, CIRF_AM_DIRECT, 8'h30, 8'h5a);
        rd_chk("low ram", CIRF_AM_INDIRECT, 8'h30, 8'h5a);
        access(1'b1, CIRF_AM_INDIRECT, 8'h7f, 8'h11);
        rd_chk("low ram", CIRF_AM_DIRECT, 8'h7f, 8'h11);
        access(1'b1, CIRF_AM_INDIRECT, 8'h90, 8'haa);
        chk("sfr write", 16'h0000, {15'h0000, sfr_write});
        rd_chk("upper ram", CIRF_AM_INDIRECT, 8'h90, 8'haa);
        chk("sfr read", 16'h0000, {15'h0000, sfr_read});
        access(1'b0, CIRF_AM_DIRECT, 8'h90, 8'h00);
        chk("sfr read", 16'h0001, {15'h0000, sfr_read});
        chk("sfr address", 16'h0090, {8'h00, sfr_addr});
        access(1'b1, CIRF_AM_DIRECT, 8'h91, 8'h3c);
        chk("sfr write", 16'h0001, {15'h0000, sfr_write});
        chk("sfr data", 16'h003c, {8'h00, sfr_wdata});
        access(1'b1, CIRF_AM_INDIRECT, CIRF_SP_ADDR, 8'h66);
        chk("stack pointer", 16'h0007, {8'h00, stack_pointer});
        rd_chk("upper ram", CIRF_AM_INDIRECT, CIRF_SP_ADDR, 8'h66);
        $display("test memory map done");
        // one distinct byte into register 3 of each bank
        for (int i = 0; i < 4; i++) begin
            access(1'b1, CIRF_AM_DIRECT, CIRF_PSW_ADDR, 8'(i << 3));
            access(1'b1, CIRF_AM_REGISTER, 8'h03, 8'(8'h40 + i));
        end
        rd_chk("bank register", CIRF_AM_REGISTER, 8'h03, 8'h43);
        for (int i = 0; i < 4; i++) begin
            rd_chk("bank byte", CIRF_AM_DIRECT, 8'(i * 8 + 3), 8'(8'h40 + i));
        end
        access(1'b1, CIRF_AM_DIRECT, CIRF_PSW_ADDR, 8'h00);
        $display("test banks done");
        // bit area top edge, a low bit and status word bits
        access(1'b1, CIRF_AM_DIRECT, 8'h21, 8'h00);
        access(1'b1, CIRF_AM_DIRECT, 8'h2f, 8'h00);
        access(1'b1, CIRF_AM_BIT, 8'h0a, 8'h01);
        access(1'b1, CIRF_AM_BIT, 8'h7f, 8'h01);
        rd_chk("bit byte", CIRF_AM_DIRECT, 8'h21, 8'h04);
        rd_chk("bit byte", CIRF_AM_DIRECT, 8'h2f, 8'h80);
        rd_chk("bit", CIRF_AM_BIT, 8'h0a, 8'h01);
        access(1'b1, CIRF_AM_BIT, 8'hd5, 8'h01);
        access(1'b1, CIRF_AM_BIT, 8'hd1, 8'h01);
        chk("status word", 16'h0022, {8'h00, program_status_word});
        exp_psw = 8'h22;
        $display("test bits done");
        // flag table; user flags must ride through untouched
        alu_chk(CIRF_OP_ADD, 8'h7f, 8'h01, 1'b0);
        alu_chk(CIRF_OP_ADD, 8'hff, 8'h00, 1'b1);
        alu_chk(CIRF_OP_ADD, 8'h12, 8'h21, 1'b0);
        alu_chk(CIRF_OP_SUB, 8'h00, 8'h01, 1'b0);
        alu_chk(CIRF_OP_SUB, 8'h80, 8'h00, 1'b1);
        alu_chk(CIRF_OP_MUL, 8'h10, 8'h10, 1'b0);
        alu_chk(CIRF_OP_MUL, 8'h02, 8'h03, 1'b0);
        alu_chk(CIRF_OP_DIV, 8'h07, 8'h00, 1'b0);
        alu_chk(CIRF_OP_DIV, 8'h07, 8'h02, 1'b0);
        alu_chk(CIRF_OP_OTHER, 8'h01, 8'h00, 1'b1);
        $display("test flags done");
        // pre-increment push, back to back across the 8-bit wrap
        req.wdata = 8'hc3;
        push = 1'b1;
        step;
        push = 1'b0;
        chk("stack pointer", 16'h0008, {8'h00, stack_pointer});
        rd_chk("stack byte", CIRF_AM_INDIRECT, 8'h08, 8'hc3);
        access(1'b1, CIRF_AM_DIRECT, CIRF_SP_ADDR, 8'hfe);
        req.wdata = 8'ha1;
        push = 1'b1;
        step;
        req.wdata = 8'ha2;
        step;
        push = 1'b0;
        chk("stack pointer", 16'h0000, {8'h00, stack_pointer});
        rd_chk("stack byte", CIRF_AM_INDIRECT, 8'hff, 8'ha1);
        rd_chk("stack byte", CIRF_AM_INDIRECT, 8'h00, 8'ha2);
        pop = 1'b1;
        step;
        pop = 1'b0;
        chk("stack pointer", 16'h00ff, {8'h00, stack_pointer});
        $display("test stack done");
        // back-to-back vector loads, one per cycle
        irq_take = 1'b1;
        for (int i = 0; i < 5; i++) begin
            irq_index = 3'(i);
            step;
            chk("fetch load", 16'h0001, {15'h0000, fetch_load});
            chk("vector", 16'h0003 + 16'(i * 8), fetch_addr);
        end
        irq_take = 1'b0;
        $display("test vectors done");
        do_reset;
        finish_test;
    end
endmodule
